//--- hw/dwsp_top.sv
// Purpose: Write-only serial receiver setting two 256-tap wiper positions.
// Assumes: clk_i is much faster than the serial clock, at least eight times.
// Notes: A frame is chip select low, sixteen rising serial clock edges, chip select high.
`default_nettype none
`timescale 1ns/100ps
module dwsp_top
	import dwsp_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Serial link pins, all inputs from the master.
	input wire logic serial_clk_i,
	input wire logic serial_din_i,
	input wire logic chip_sel_n_i,
	// Wiper positions driving the resistor ladders.
	output logic [7:0] wiper_a_position_o,
	output logic [7:0] wiper_b_position_o,
	// One-cycle pulse when a wiper was written.
	output logic wiper_a_update_o,
	output logic wiper_b_update_o
);
	logic sclk_s;
	logic din_s;
	logic csn_s;
	logic sclk_d;
	logic rise;
	logic [15:0] shift;
	logic [4:0] bit_count;
	dwsp_state_t state;
	logic [2:0] sync_in;
	logic [2:0] sync_out;

	// All three pins pass through two flip-flops before use.
	// Chip select is inverted before the synchroniser so that its reset value of zero reads as deselected.
	// Otherwise a false frame start would follow every reset.
	assign sync_in = {serial_clk_i, serial_din_i, ~chip_sel_n_i};
	generate
		for (genvar g = 0; g < 3; g++) begin : g_sync
			dwsp_sync dwsp_sync_i (
				.clk_i(clk_i),
				.rst_n_i(rst_n_i),
				.async_i(sync_in[g]),
				.sync_o(sync_out[g])
			);
		end
	endgenerate
	assign sclk_s = sync_out[2];
	assign din_s = sync_out[1];
	assign csn_s = ~sync_out[0];

	// Rising serial clock is the sampling edge since the clock idles low.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_d <= 1'b0;
		end else begin
			sclk_d <= sclk_s;
		end
	end
	assign rise = sclk_s & ~sclk_d & ~csn_s;

	// Frame state: chip select low opens, sixteen bits fill, chip select high closes.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= DWSP_IDLE;
		end else begin
			case (state)
				DWSP_IDLE: begin
					if (!csn_s) begin
						state <= DWSP_SHIFT;
					end
				end
				DWSP_SHIFT: begin
					if (csn_s) begin
						state <= DWSP_IDLE; // Partial frame dropped.
					end else if (rise && bit_count == DWSP_FRAME_BITS - 5'h01) begin
						state <= DWSP_DONE;
					end
				end
				DWSP_DONE: begin
					if (csn_s) begin
						state <= DWSP_IDLE;
					end
				end
				default: begin
					state <= DWSP_IDLE;
				end
			endcase
		end
	end

	// Shift in MSB first; the first bit ends up in the top of the register.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift <= 16'h0000;
			bit_count <= 5'h00;
		end else if (state != DWSP_SHIFT || csn_s) begin
			bit_count <= 5'h00; // Cleared as soon as the frame is cut.
		end else if (rise) begin
			shift <= {shift[14:0], din_s};
			// The count wraps on the sixteenth bit so it never leaves the frame range.
			if (bit_count == DWSP_FRAME_BITS - 5'h01) begin
				bit_count <= 5'h00;
			end else begin
				bit_count <= bit_count + 5'h01;
			end
		end
	end

	// The frame completes when the sixteenth bit lands; extra clocks are ignored.
	logic frame_done;
	logic [15:0] frame_word;
	assign frame_done = (state == DWSP_SHIFT) && rise && !csn_s && (bit_count == DWSP_FRAME_BITS - 5'h01);
	assign frame_word = {shift[14:0], din_s};

	// Wiper registers; any other command is ignored. Nothing is ever shifted out.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wiper_a_position_o <= DWSP_WIPER_RESET;
			wiper_b_position_o <= DWSP_WIPER_RESET;
			wiper_a_update_o <= 1'b0;
			wiper_b_update_o <= 1'b0;
		end else begin
			wiper_a_update_o <= 1'b0;
			wiper_b_update_o <= 1'b0;
			if (frame_done && frame_word[15:8] == DWSP_CMD_WIPER_A) begin
				wiper_a_position_o <= frame_word[DWSP_BYTE_BITS - 5'h01:0];
				wiper_a_update_o <= 1'b1;
			end
			if (frame_done && frame_word[15:8] == DWSP_CMD_WIPER_B) begin
				wiper_b_position_o <= frame_word[DWSP_BYTE_BITS - 5'h01:0];
				wiper_b_update_o <= 1'b1;
			end
		end
	end

	// Checks beside the logic.
	property p_wa_load;
		@(posedge clk_i) disable iff (!rst_n_i)
		(frame_done && frame_word[15:8] == DWSP_CMD_WIPER_A) |=>
			(wiper_a_position_o == $past(frame_word[7:0]) && wiper_a_update_o);
	endproperty
	a_wa_load: assert property (p_wa_load) else $error("Wiper A not loaded.");
	property p_wb_load;
		@(posedge clk_i) disable iff (!rst_n_i)
		(frame_done && frame_word[15:8] == DWSP_CMD_WIPER_B) |=>
			(wiper_b_position_o == $past(frame_word[7:0]) && wiper_b_update_o);
	endproperty
	a_wb_load: assert property (p_wb_load) else $error("Wiper B not loaded.");
	property p_wa_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		!wiper_a_update_o |-> $stable(wiper_a_position_o) || $past(!rst_n_i);
	endproperty
	a_wa_hold: assert property (p_wa_hold) else $error("Wiper A changed without write.");
	property p_wb_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		!wiper_b_update_o |-> $stable(wiper_b_position_o) || $past(!rst_n_i);
	endproperty
	a_wb_hold: assert property (p_wb_hold) else $error("Wiper B changed without write.");
	property p_one_wiper;
		@(posedge clk_i) disable iff (!rst_n_i)
		!(wiper_a_update_o && wiper_b_update_o);
	endproperty
	a_one_wiper: assert property (p_one_wiper) else $error("Both wipers written at once.");
	property p_abort;
		@(posedge clk_i) disable iff (!rst_n_i)
		(state == DWSP_SHIFT && csn_s) |=> (state == DWSP_IDLE && bit_count == 5'h00);
	endproperty
	a_abort: assert property (p_abort) else $error("Short frame not discarded.");
	property p_msb_first;
		@(posedge clk_i) disable iff (!rst_n_i)
		(state == DWSP_SHIFT && rise) |=> shift[0] == $past(din_s);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("Bit not shifted in at bottom.");
	property p_no_shift_idle;
		@(posedge clk_i) disable iff (!rst_n_i)
		(csn_s || !(sclk_s && !sclk_d)) |=> $stable(shift);
	endproperty
	a_no_shift_idle: assert property (p_no_shift_idle) else $error("Shift outside rising edge.");
	property p_count_max;
		@(posedge clk_i) disable iff (!rst_n_i)
		bit_count <= DWSP_FRAME_BITS - 5'h01;
	endproperty
	a_count_max: assert property (p_count_max) else $error("Bit count overran frame.");
	c_write_a: cover property (@(posedge clk_i) disable iff (!rst_n_i) wiper_a_update_o);
	c_write_b: cover property (@(posedge clk_i) disable iff (!rst_n_i) wiper_b_update_o);
	c_abort: cover property (@(posedge clk_i) disable iff (!rst_n_i) state == DWSP_SHIFT && csn_s && bit_count != 5'h00);
endmodule // dwsp_top
`default_nettype wire

//--- hw/dwsp_pkg.sv
// Purpose: Shared constants for the dual wiper serial write port.
// Assumes: Mode 0 serial link, MSB first, command byte then data byte.
// Notes: Wiper positions are eight bits wide, one value per tap.
`default_nettype none
package dwsp_pkg;
	// Command codes that select a wiper.
	localparam logic [7:0] DWSP_CMD_WIPER_A = 8'h00;
	localparam logic [7:0] DWSP_CMD_WIPER_B = 8'h01;
	// Register offsets, equal to the command codes.
	localparam logic [7:0] DWSP_OFS_WIPER_A = 8'h00;
	localparam logic [7:0] DWSP_OFS_WIPER_B = 8'h01;
	// Midscale reset value of both wipers.
	localparam logic [7:0] DWSP_WIPER_RESET = 8'h80;
	// Bits in one frame and in one byte.
	localparam logic [4:0] DWSP_FRAME_BITS = 5'h10;
	localparam logic [4:0] DWSP_BYTE_BITS = 5'h08;
	// Frame receiver states.
	typedef enum logic [1:0] {DWSP_IDLE, DWSP_SHIFT, DWSP_DONE} dwsp_state_t;
endpackage
`default_nettype wire

//--- hw/dwsp_sync.sv
// Purpose: Two flip-flop synchroniser for the serial pins.
// Assumes: Inputs are asynchronous to clk_i.
// Notes: The first stage is read only by the second stage.
`default_nettype none
`timescale 1ns/100ps
module dwsp_sync (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Pin side.
	input wire logic async_i,
	// Synchronised side.
	output logic sync_o
);
	logic stage1;

	// Two stages keep metastability away from the decode logic.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage1 <= 1'b0;
			sync_o <= 1'b0;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule // dwsp_sync
`default_nettype wire

//--- tb/dwsp_master.sv
// Purpose: Behavioural serial master that writes frames to the wiper port.
// Assumes: Mode 0 link, 160 ns serial clock period, clk_i at 4 ns.
// Notes: Data flips to its inverse once the frame ends, so stale bits never look valid.
`default_nettype none
`timescale 1ns/100ps
module dwsp_master (
	// System clock used for pacing.
	input wire logic clk_i,
	// Serial pins toward the port.
	output logic serial_clk_o,
	output logic serial_din_o,
	output logic chip_sel_n_o
);
	// Idle: clock low, frame closed.
	initial begin
		serial_clk_o = 1'b0;
		serial_din_o = 1'b0;
		chip_sel_n_o = 1'b1;
	end
	// Sends the top nbits of word, command byte then data byte, in one frame.
	task automatic send(input logic [15:0] word, input int nbits);
		@(posedge clk_i) chip_sel_n_o <= 1'b0;
		repeat (20) @(posedge clk_i);
		for (int i = 0; i < nbits; i++) begin
			serial_din_o <= word[15 - i];
			repeat (20) @(posedge clk_i);
			serial_clk_o <= 1'b1;
			repeat (20) @(posedge clk_i);
			serial_clk_o <= 1'b0;
		end
		repeat (20) @(posedge clk_i);
		chip_sel_n_o <= 1'b1;
		serial_din_o <= ~serial_din_o;
		repeat (20) @(posedge clk_i);
	endtask
endmodule // dwsp_master
`default_nettype wire

//--- tb/dual_wiper_serial_write_port_test.sv
// Purpose: Self-checking bench for the dual wiper serial write port.
// Assumes: Positions settle within the master's closing idle time.
// Notes: Update pulses are counted per frame to catch missing or extra writes.
`default_nettype none
`timescale 1ns/100ps
module dual_wiper_serial_write_port_test;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic sclk, sdin, csn;
	logic [7:0] pos_a, pos_b;
	logic upd_a, upd_b;
	int n_errors = 0;
	int total_checks = 0;
	int pa = 0;
	int pb = 0;
	// 250 MHz system clock.
	always #2 clk_i = ~clk_i;
	dwsp_master dwsp_master_i (.clk_i(clk_i), .serial_clk_o(sclk), .serial_din_o(sdin), .chip_sel_n_o(csn));
	dwsp_top dwsp_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .serial_clk_i(sclk), .serial_din_i(sdin),
		.chip_sel_n_i(csn), .wiper_a_position_o(pos_a), .wiper_b_position_o(pos_b),
		.wiper_a_update_o(upd_a), .wiper_b_update_o(upd_b));
	// Pulse counters; a stuck pulse shows as a count above one.
	always @(posedge clk_i) begin
		if (upd_a === 1'b1) pa++;
		if (upd_b === 1'b1) pb++;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// One frame, then both positions and both pulse counts compared.
	task automatic run(input logic [15:0] w, input int nb, input logic [7:0] ea, input logic [7:0] eb,
		input logic [1:0] np);
		pa = 0;
		pb = 0;
		dwsp_master_i.send(w, nb);
		chk(pos_a, ea);
		chk(pos_b, eb);
		chk(8'(pa), {7'h00, np[1]});
		chk(8'(pb), {7'h00, np[0]});
		$display("frame %h bits %0d done", w, nb);
	endtask
	// Watchdog: a hang counts as a mismatch.
	initial begin
		repeat (100000) @(posedge clk_i);
		n_errors++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(pos_a, 8'h80);
		chk(pos_b, 8'h80);
		run(16'h007f, 16, 8'h7f, 8'h80, 2'b10);
		run(16'h01a5, 16, 8'h7f, 8'ha5, 2'b01);
		run(16'h0000, 16, 8'h00, 8'ha5, 2'b10);
		run(16'h01ff, 16, 8'h00, 8'hff, 2'b01);
		run(16'h0233, 16, 8'h00, 8'hff, 2'b00);
		run(16'h00c3, 15, 8'h00, 8'hff, 2'b00);
		run(16'h013c, 8, 8'h00, 8'hff, 2'b00);
		run(16'h00c3, 16, 8'hc3, 8'hff, 2'b10);
		// Mid-run reset must return both wipers to midscale, then writes work again.
		rst_n_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(pos_a, 8'h80);
		chk(pos_b, 8'h80);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(pos_a, 8'h80);
		chk(pos_b, 8'h80);
		$display("mid-run reset done");
		run(16'h013c, 16, 8'h80, 8'h3c, 2'b01);
		wrap_up();
	end
endmodule // dual_wiper_serial_write_port_test
`default_nettype wire
